// [common/lhcr_consts.svh]
`ifndef LHCR_CONSTS_SVH
`define LHCR_CONSTS_SVH
// Register addresses on the serial register port
`define LHCR_ADDR_CH_CFG 6'h1e
`define LHCR_ADDR_FAULT_CFG 6'h1f
`define LHCR_ADDR_EXT_LOW 6'h20
`define LHCR_ADDR_EXT_HIGH 6'h21
`define LHCR_ADDR_FILT_LOW 6'h22
`define LHCR_ADDR_FILT_HIGH 6'h23
// Reset values
`define LHCR_CH_CFG_RST 8'h00
`define LHCR_FAULT_CFG_RST 8'h00
// Channel config field positions
`define LHCR_BIT_CH1_EN 0
`define LHCR_BIT_CH1_INTPWM 1
`define LHCR_BIT_CH2_EN 3
`define LHCR_BIT_EXT_SEL 6
// Fault config field positions
`define LHCR_BIT_CH1_LS 0
`define LHCR_BIT_CH1_HS 1
`define LHCR_BIT_CH1_TS 2
`define LHCR_BIT_CH2_LS 3
`define LHCR_BIT_CH2_HS 4
`define LHCR_BIT_CH2_TS 5
`define LHCR_TIMER_MSB 7
`define LHCR_TIMER_LSB 6
// Fault timer base limit in microseconds (3.6 ms), doubled per code step
`define LHCR_TIMER_BASE_US 3600
`define LHCR_CLK_MHZ 250
`define LHCR_TIMER_BASE_CYC (`LHCR_TIMER_BASE_US * `LHCR_CLK_MHZ)
`endif

// [common/lhcr_pkg.sv]
package lhcr_pkg;
	typedef struct packed {
		logic thermal;
		logic high_limit;
		logic low_limit;
	} lhcr_fault_t;
	typedef struct packed {
		logic [5:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} lhcr_req_t;
	typedef enum logic [1:0] {
		LHCR_RUN = 2'b00,
		LHCR_WAIT = 2'b01,
		LHCR_LATCHED = 2'b10
	} lhcr_state_t;
endpackage : lhcr_pkg

// [rtl/lhcr_fault_timer.sv]
`timescale 1ns/10ps
`include "lhcr_consts.svh"
// Overcurrent fault timer; limit doubles with each step of the limit code
module lhcr_fault_timer #(
	parameter int unsigned BASE_CYC = `LHCR_TIMER_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire logic [1:0] i_limit,
	output logic o_expired
);
	logic [25:0] cnt_ff;
	logic running_ff;
	logic [25:0] limit;

	assign limit = 26'(BASE_CYC) << i_limit;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_ff <= 26'h000_0000;
			running_ff <= 1'b0;
			o_expired <= 1'b0;
		end else begin
			o_expired <= 1'b0;
			if (i_start) begin
				cnt_ff <= 26'h000_0001;
				running_ff <= 1'b1;
			end else if (running_ff) begin
				if (cnt_ff >= limit) begin
					running_ff <= 1'b0;
					o_expired <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 26'h000_0001;
				end
			end
		end
	end
endmodule : lhcr_fault_timer

// [rtl/lhcr_channel_guard.sv]
`timescale 1ns/10ps
`include "lhcr_consts.svh"
// Per-channel limp-home fault response: auto-restart or latch-off
module lhcr_channel_guard #(
	parameter int unsigned BASE_CYC = `LHCR_TIMER_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire lhcr_pkg::lhcr_fault_t i_fault,
	input wire lhcr_pkg::lhcr_fault_t i_latch_sel,
	input wire logic [1:0] i_limit,
	output logic o_run,
	output logic o_clear_en
);
	lhcr_pkg::lhcr_state_t state_ff;
	lhcr_pkg::lhcr_state_t nxt_state;
	logic switch_current_limit;
	logic latch_now;
	logic start;
	logic expired;

	assign switch_current_limit = i_fault.high_limit | i_fault.low_limit;
	assign latch_now = (i_fault.thermal & i_latch_sel.thermal)
		| (i_fault.high_limit & i_latch_sel.high_limit)
		| (i_fault.low_limit & i_latch_sel.low_limit);
	assign start = (state_ff == lhcr_pkg::LHCR_RUN) && switch_current_limit && !latch_now;

	lhcr_fault_timer #(.BASE_CYC(BASE_CYC)) u_timer (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_start(start),
		.i_limit(i_limit),
		.o_expired(expired)
	);

	always_comb begin
		nxt_state = state_ff;
		o_clear_en = 1'b0;
		case (state_ff)
			lhcr_pkg::LHCR_RUN: begin
				if (latch_now) begin
					nxt_state = lhcr_pkg::LHCR_LATCHED;
					o_clear_en = 1'b1;
				end else if (switch_current_limit) begin
					nxt_state = lhcr_pkg::LHCR_WAIT;
				end
			end
			lhcr_pkg::LHCR_WAIT: begin
				if (latch_now) begin
					nxt_state = lhcr_pkg::LHCR_LATCHED;
					o_clear_en = 1'b1;
				end else if (expired) begin
					nxt_state = lhcr_pkg::LHCR_RUN;
				end
			end
			lhcr_pkg::LHCR_LATCHED: begin
				if (!i_enable) begin
					nxt_state = lhcr_pkg::LHCR_RUN;
				end
			end
			default: nxt_state = lhcr_pkg::LHCR_RUN;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= lhcr_pkg::LHCR_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Thermal auto-restart follows the detector's own hysteresis level
	assign o_run = i_enable && (state_ff == lhcr_pkg::LHCR_RUN) && !i_fault.thermal && !switch_current_limit;
endmodule : lhcr_channel_guard

// [rtl/lhcr_limp_regs.sv]
`timescale 1ns/10ps
`include "lhcr_consts.svh"
// Functional notes
// - Channel config bit 1 picks internal PWM (1) or external dim input (0)
// - Channel config bit 0 runs channel 1 in limp-home; resets to 0
// - Fault config bits 7-6 pick overcurrent timer 3.6, 7.2, 14.4, 28.8 ms
// - Bit 5: channel 2 thermal shutdown auto-restarts (0) or latches off (1)
// - Bit 4: channel 2 high-side limit auto-restarts after timer or latches off
// - Bit 3: channel 2 low-side limit auto-restarts after timer or latches off
// - Bit 2: channel 1 thermal shutdown auto-restarts or latches off
// - Bit 1: channel 1 high-side limit auto-restarts after timer or latches off
// - Bit 0: channel 1 low-side limit auto-restarts after timer or latches off
// - External reference is digitised to a 10-bit code, 2.45/1023 V per step
// - External reference low byte gives code bits 1-0; bits 7-2 read zero
// - External reference high byte gives code bits 9-2; read-only
// - Filtered low byte updates only when filtered high byte is read
// - External-reference select makes the digitised reference the current setting
module lhcr_limp_regs #(
	parameter int unsigned BASE_CYC = `LHCR_TIMER_BASE_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire lhcr_pkg::lhcr_req_t i_req,
	input wire logic [9:0] i_ext_ref_code,
	input wire logic i_ext_ref_valid,
	input wire logic [9:0] i_filt_ref_code,
	input wire logic [9:0] i_ch1_int_current,
	input wire logic [9:0] i_ch2_int_current,
	input wire lhcr_pkg::lhcr_fault_t i_ch1_fault,
	input wire lhcr_pkg::lhcr_fault_t i_ch2_fault,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_ch1_run,
	output logic o_ch2_run,
	output logic o_ch1_internal_dim_select,
	output logic [9:0] o_ch1_current_setting,
	output logic [9:0] o_ch2_current_setting,
	output logic [1:0] o_overcurrent_timer_limit
);
	logic [7:0] ch_cfg_ff;
	logic [7:0] fault_cfg_ff;
	logic [9:0] ext_ref_ff;
	logic [1:0] filt_low_ff;
	logic ch1_clear;
	logic ch2_clear;
	logic ch1_run;
	logic ch2_run;
	lhcr_pkg::lhcr_fault_t ch1_sel;
	lhcr_pkg::lhcr_fault_t ch2_sel;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
		hit = (a == target);
	endfunction : hit

	// Software enable bits; a latch-off clear loses to a write in the same cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ch_cfg_ff <= `LHCR_CH_CFG_RST;
		end else begin
			if (ch1_clear) begin
				ch_cfg_ff[`LHCR_BIT_CH1_EN] <= 1'b0;
			end
			if (ch2_clear) begin
				ch_cfg_ff[`LHCR_BIT_CH2_EN] <= 1'b0;
			end
			if (i_req.wr && hit(i_req.addr, `LHCR_ADDR_CH_CFG)) begin
				ch_cfg_ff <= i_req.wdata;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fault_cfg_ff <= `LHCR_FAULT_CFG_RST;
		end else if (i_req.wr && hit(i_req.addr, `LHCR_ADDR_FAULT_CFG)) begin
			fault_cfg_ff <= i_req.wdata;
		end
	end

	// Measurement registers take only converter data; bus writes never reach them
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ext_ref_ff <= 10'h000;
		end else if (i_ext_ref_valid) begin
			ext_ref_ff <= i_ext_ref_code;
		end
	end

	// Low byte snapshot keeps the pair coherent while the filter moves on
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			filt_low_ff <= 2'h0;
		end else if (i_req.rd && hit(i_req.addr, `LHCR_ADDR_FILT_HIGH)) begin
			filt_low_ff <= i_filt_ref_code[1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			if (i_req.rd) begin
				case (i_req.addr)
					`LHCR_ADDR_CH_CFG: o_rdata <= ch_cfg_ff;
					`LHCR_ADDR_FAULT_CFG: o_rdata <= fault_cfg_ff;
					`LHCR_ADDR_EXT_LOW: o_rdata <= {6'h00, ext_ref_ff[1:0]};
					`LHCR_ADDR_EXT_HIGH: o_rdata <= ext_ref_ff[9:2];
					`LHCR_ADDR_FILT_LOW: o_rdata <= {6'h00, filt_low_ff};
					`LHCR_ADDR_FILT_HIGH: o_rdata <= i_filt_ref_code[9:2];
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end

	assign ch1_sel = '{thermal: fault_cfg_ff[`LHCR_BIT_CH1_TS],
		high_limit: fault_cfg_ff[`LHCR_BIT_CH1_HS],
		low_limit: fault_cfg_ff[`LHCR_BIT_CH1_LS]};
	assign ch2_sel = '{thermal: fault_cfg_ff[`LHCR_BIT_CH2_TS],
		high_limit: fault_cfg_ff[`LHCR_BIT_CH2_HS],
		low_limit: fault_cfg_ff[`LHCR_BIT_CH2_LS]};

	lhcr_channel_guard #(.BASE_CYC(BASE_CYC)) u_ch1 (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_enable(ch_cfg_ff[`LHCR_BIT_CH1_EN]),
		.i_fault(i_ch1_fault),
		.i_latch_sel(ch1_sel),
		.i_limit(fault_cfg_ff[`LHCR_TIMER_MSB:`LHCR_TIMER_LSB]),
		.o_run(ch1_run),
		.o_clear_en(ch1_clear)
	);

	lhcr_channel_guard #(.BASE_CYC(BASE_CYC)) u_ch2 (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_enable(ch_cfg_ff[`LHCR_BIT_CH2_EN]),
		.i_fault(i_ch2_fault),
		.i_latch_sel(ch2_sel),
		.i_limit(fault_cfg_ff[`LHCR_TIMER_MSB:`LHCR_TIMER_LSB]),
		.o_run(ch2_run),
		.o_clear_en(ch2_clear)
	);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ch1_run <= 1'b0;
			o_ch2_run <= 1'b0;
			o_ch1_internal_dim_select <= 1'b0;
			o_overcurrent_timer_limit <= 2'h0;
		end else begin
			o_ch1_run <= ch1_run;
			o_ch2_run <= ch2_run;
			o_ch1_internal_dim_select <= ch_cfg_ff[`LHCR_BIT_CH1_INTPWM];
			o_overcurrent_timer_limit <= fault_cfg_ff[`LHCR_TIMER_MSB:`LHCR_TIMER_LSB];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ch1_current_setting <= 10'h000;
			o_ch2_current_setting <= 10'h000;
		end else if (ch_cfg_ff[`LHCR_BIT_EXT_SEL]) begin
			o_ch1_current_setting <= ext_ref_ff;
			o_ch2_current_setting <= ext_ref_ff;
		end else begin
			o_ch1_current_setting <= i_ch1_int_current;
			o_ch2_current_setting <= i_ch2_int_current;
		end
	end
endmodule : lhcr_limp_regs

// [verif/lhcr_limp_regs_asserts.sv]
`timescale 1ns/10ps
module lhcr_limp_regs_asserts (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire lhcr_pkg::lhcr_req_t i_req,
	input wire logic [9:0] i_ext_ref_code,
	input wire logic i_ext_ref_valid,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_ch1_run,
	input wire logic o_ch1_internal_dim_select,
	input wire logic [1:0] o_overcurrent_timer_limit
);
	// Shadow of the captured code; also read before any capture, so it resets to 0 like ext_ref_ff
	logic [9:0] held_ff;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			held_ff <= 10'h000;
		end else if (i_ext_ref_valid) begin
			held_ff <= i_ext_ref_code;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	property p_rvalid; o_rvalid == $past(i_req.rd); endproperty
	a_rvalid: assert property (p_rvalid) else $error("rvalid timing");
	property p_ext_high;
		i_req.rd && i_req.addr == 6'h21 && !i_ext_ref_valid |=> o_rdata == held_ff[9:2];
	endproperty
	a_ext_high: assert property (p_ext_high) else $error("ext high byte");
	property p_ext_low;
		i_req.rd && i_req.addr == 6'h20 && !i_ext_ref_valid |=> o_rdata == {6'h00, held_ff[1:0]};
	endproperty
	a_ext_low: assert property (p_ext_low) else $error("ext low byte");
	property p_limit;
		i_req.wr && i_req.addr == 6'h1f |=> ##1
			o_overcurrent_timer_limit == $past(i_req.wdata[7:6], 2);
	endproperty
	a_limit: assert property (p_limit) else $error("timer limit");
	property p_dim;
		i_req.wr && i_req.addr == 6'h1e |=> ##1
			o_ch1_internal_dim_select == $past(i_req.wdata[1], 2);
	endproperty
	a_dim: assert property (p_dim) else $error("dim select");
	property p_ch1_off; i_req.wr && i_req.addr == 6'h1e && !i_req.wdata[0] |=> ##1 !o_ch1_run; endproperty
	a_ch1_off: assert property (p_ch1_off) else $error("ch1 still runs");
	property p_unmapped;
		i_req.rd && (i_req.addr > 6'h23 || i_req.addr < 6'h1e) |=> o_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_reset; $rose(i_nrst) |-> !o_ch1_run && !o_rvalid && o_rdata == 8'h00; endproperty
	a_reset: assert property (p_reset) else $error("reset outputs");
endmodule : lhcr_limp_regs_asserts
bind lhcr_limp_regs lhcr_limp_regs_asserts u_chk (.i_clk, .i_nrst, .i_req, .i_ext_ref_code,
	.i_ext_ref_valid, .o_rdata, .o_rvalid, .o_ch1_run, .o_ch1_internal_dim_select,
	.o_overcurrent_timer_limit);

// [verif/lhcr_host_model.sv]
`timescale 1ns/10ps
module lhcr_host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	output lhcr_pkg::lhcr_req_t o_req
);
	initial o_req = '0;
	// Released data is inverted so a stale value never looks valid
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge i_clk) o_req <= '{a, 1'b1, 1'b0, d};
		@(posedge i_clk) o_req <= '{a, 1'b0, 1'b0, ~d};
		#1;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge i_clk) o_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge i_clk) o_req <= '{~a, 1'b0, 1'b0, 8'hff};
		#1 d = i_rvalid ? i_rdata : 8'hxx;
	endtask : rd
	task automatic rd_filt(output logic [9:0] v);
		logic [7:0] h;
		logic [7:0] l;
		rd(6'h23, h);
		rd(6'h22, l);
		v = {h, l[1:0]};
	endtask : rd_filt
endmodule : lhcr_host_model

// [verif/lhcr_limp_regs_bench.sv]
`timescale 1ns/10ps
module lhcr_limp_regs_bench;
	localparam int unsigned BASE = 20;
	logic clk = 0, nrst = 0, ev = 0, dim, c1, c2, dsel;
	logic [9:0] ext = 0, filt = 0, in1, in2, cur1, cur2, w;
	lhcr_pkg::lhcr_fault_t f1 = '0, f2 = '0;
	lhcr_pkg::lhcr_req_t req;
	logic [7:0] d, rv;
	logic [1:0] lim;
	logic [31:0] seed = 32'he991, v;
	int failures = 0, n_compared = 0;
	always #2 clk = ~clk;
	lhcr_host_model h (.i_clk(clk), .i_rdata(d), .i_rvalid(c2), .o_req(req));
	lhcr_limp_regs #(.BASE_CYC(BASE)) dut_u (.i_clk(clk), .i_nrst(nrst), .i_req(req),
		.i_ext_ref_code(ext), .i_ext_ref_valid(ev), .i_filt_ref_code(filt),
		.i_ch1_int_current(in1), .i_ch2_int_current(in2), .i_ch1_fault(f1), .i_ch2_fault(f2),
		.o_rdata(d), .o_rvalid(c2), .o_ch1_run(c1), .o_ch2_run(dim),
		.o_ch1_internal_dim_select(dsel), .o_ch1_current_setting(cur1),
		.o_ch2_current_setting(cur2), .o_overcurrent_timer_limit(lim));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] lo_byte(input logic [9:0] c);
		return {6'h00, c[1:0]};
	endfunction : lo_byte
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		report_and_stop();
	end
	initial begin
		in1 <= 10'(rnd());
		in2 <= 10'(rnd());
		repeat (6) @(posedge clk);
		nrst <= 1;
		h.rd(6'h1e, rv); chk("ch_cfg", 0, rv);
		h.rd(6'h1f, rv); chk("fault_cfg", 0, rv);
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			h.wr(6'h1f, {2'(i), v[5:0]});
			// The limit output is registered from the stored field, one edge later
			@(posedge clk);
			#1 chk("limit", 10'(i), lim);
			h.rd(6'h1f, rv); chk("fault_cfg", {2'(i), v[5:0]}, rv);
		end
		$display("test config done");
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			@(posedge clk) ext <= v[9:0];
			ev <= 1;
			@(posedge clk) ev <= 0;
			ext <= ~v[9:0];
			h.wr(6'h20 + 6'(i), v[17:10]);
			h.rd(6'h21, rv); chk("ext_high", v[9:2], rv);
			h.rd(6'h20, rv); chk("ext_low", lo_byte(v[9:0]), rv);
		end
		h.rd(6'h3f, rv); chk("unmapped", 0, rv);
		h.wr(6'h1e, 8'h42);
		repeat (3) @(posedge clk); #1 chk("cur_ext", v[9:0], cur1);
		chk("cur2_ext", v[9:0], cur2);
		chk("dim_sel", 1, dsel);
		h.wr(6'h1e, 8'h00);
		repeat (3) @(posedge clk); #1 chk("cur_int", in1, cur1);
		chk("cur2_int", in2, cur2);
		chk("dim_sel", 0, dsel);
		v = rnd();
		@(posedge clk) filt <= v[9:0];
		h.rd_filt(w); chk("filt", v[9:0], w);
		@(posedge clk) filt <= ~v[9:0];
		h.rd(6'h22, rv); chk("filt_low", lo_byte(v[9:0]), rv);
		$display("test readback done");
		for (int i = 0; i < 6; i++) begin
			h.wr(6'h1e, 8'h0b);
			h.wr(6'h1f, 8'(1 << i));
			chk("run", 1, i < 3 ? c1 : dim);
			@(posedge clk) f1 <= i < 3 ? 3'(1 << i) : 3'b000;
			f2 <= i < 3 ? 3'b000 : 3'(1 << (i - 3));
			repeat (3) @(posedge clk) f1 <= 0;
			f2 <= 0;
			repeat (3) @(posedge clk); #1 chk("latched", 0, i < 3 ? c1 : dim);
			h.rd(6'h1e, rv); chk("en_clear", i < 3 ? 8'h0a : 8'h03, rv);
		end
		$display("test latch done");
		h.wr(6'h1e, 8'h01);
		// One-cycle low-side fault per timer code; run must stay off for the whole limit
		for (int k = 0; k < 4; k++) begin
			h.wr(6'h1f, {2'(k), 6'h00});
			@(posedge clk) f1 <= 3'b001;
			@(posedge clk) f1 <= 3'b000;
			repeat ((BASE << k) - 1) @(posedge clk);
			#1 chk("restart_wait", 0, c1);
			repeat (5) @(posedge clk);
			#1 chk("restart", 1, c1);
		end
		$display("test restart done");
		report_and_stop();
	end
endmodule : lhcr_limp_regs_bench
